// ### design/strap_cfg_pkg.sv
package strap_cfg_pkg;
    // =========================================================
    // Pin counts and index widths
    localparam int NUM_GPIO = 16;
    localparam int CFG_IDX_W = NUM_GPIO;
    localparam int DFLT_IDX_W = 4;
    localparam int PROTO_PIN = 9;
    localparam int MUST_HIGH_PIN = 8;
    localparam int POS_W = 5;
    // =========================================================
    // Register file geometry and offsets
    localparam int REG_W = 8;
    localparam int NREG = 8;
    localparam int REG_IDX_W = 3;
    localparam int NVM_ADDR_W = 8;
    localparam logic [REG_IDX_W-1:0] REG_CLK_OUT_EN = 3'h0;
    localparam logic [REG_IDX_W-1:0] REG_GPIO_MODE_LO = 3'h1;
    localparam logic [REG_IDX_W-1:0] REG_GPIO_MODE_HI = 3'h2;
    localparam logic [REG_IDX_W-1:0] REG_PORT_CFG = 3'h3;
    // Field positions inside the port configuration register
    localparam int PORT_CFG_I2C_BIT = 0;
    localparam int PORT_CFG_ADDR2_BIT = 1;
    // =========================================================
    // Reset values: clock outputs off, every pin a plain input
    localparam logic [REG_W-1:0] RST_CLK_OUT_EN = 8'h00;
    localparam logic [REG_W-1:0] RST_GPIO_MODE = 8'h00;
    localparam logic [REG_W-1:0] RST_PORT_CFG = 8'h00;
    localparam logic [REG_W-1:0] RST_GENERAL = 8'h00;
    localparam logic [NREG-1:0][REG_W-1:0] RF_DEFAULTS = {RST_GENERAL, RST_GENERAL, RST_GENERAL, RST_GENERAL,
        RST_PORT_CFG, RST_GPIO_MODE, RST_GPIO_MODE, RST_CLK_OUT_EN};
    // Checksum residue of a good stored configuration
    localparam logic [REG_W-1:0] CSUM_GOOD = 8'h00;
    // =========================================================
    // Start-up sequencer states, Gray coded along the path
    typedef enum logic [2:0] {
        S_CAPTURE = 3'b000,
        S_DEFAULT = 3'b001,
        S_STRAP = 3'b011,
        S_REQ = 3'b010,
        S_LOAD = 3'b110,
        S_CHECK = 3'b111,
        S_DONE = 3'b101
    } boot_state_t;
endpackage

// ### design/strap_gather.sv
`timescale 1ns/1ps
module strap_gather import strap_cfg_pkg::*; (
    input wire logic [NUM_GPIO-1:0] level,
    input wire logic [NUM_GPIO-1:0] mask,
    output logic [NUM_GPIO-1:0] packed_val,
    output logic top_val,
    output logic any_high,
    output logic any_sel
);
    // =========================================================
    // Packing chain
    localparam logic [NUM_GPIO-1:0] ONE = 16'h0001;
    // Running count of selected pins below each position
    logic [NUM_GPIO:0][POS_W-1:0] pos;
    // Running OR of packed bits
    logic [NUM_GPIO:0][NUM_GPIO-1:0] acc;
    // Level of the highest selected pin seen so far
    logic [NUM_GPIO:0] top;

    assign pos[0] = '0;
    assign acc[0] = '0;
    assign top[0] = 1'b0;

    // Each selected pin lands on the next free bit, lowest pin at bit zero
    for (genvar i = 0; i < NUM_GPIO; i++) begin : g_pin
        assign pos[i+1] = pos[i] + POS_W'(mask[i]);
        assign acc[i+1] = acc[i] | ((mask[i] && level[i]) ? (ONE << pos[i][POS_W-2:0]) : '0); // RULE13
        // A higher selected pin overrides all lower ones
        assign top[i+1] = mask[i] ? level[i] : top[i]; // RULE7
    end

    // Unused upper bits stay zero by construction
    assign packed_val = acc[NUM_GPIO]; // RULE14
    assign top_val = top[NUM_GPIO];
    assign any_high = |(mask & level); // RULE10
    assign any_sel = |mask;
endmodule // strap_gather

// ### design/cfg_reg_file.sv
`timescale 1ns/1ps
module cfg_reg_file import strap_cfg_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic load_default,
    input wire logic wr_en,
    input wire logic [REG_IDX_W-1:0] wr_addr,
    input wire logic [REG_W-1:0] wr_data,
    input wire logic stage_en,
    input wire logic [REG_IDX_W-1:0] stage_addr,
    input wire logic [REG_W-1:0] stage_data,
    input wire logic commit,
    input wire logic discard,
    input wire logic [REG_IDX_W-1:0] rd_addr,
    output logic [REG_W-1:0] rd_data,
    output logic [NREG-1:0][REG_W-1:0] regs_out
);
    // =========================================================
    // State
    typedef struct packed {
        logic [NREG-1:0][REG_W-1:0] regs;  // Live registers
        logic [NREG-1:0][REG_W-1:0] stage; // Words of a load not yet checked
        logic [NREG-1:0] staged;           // Which staged words are valid
        logic [REG_W-1:0] rd_data;         // Registered read port
    } rf_state_t;

    rf_state_t s_q;
    rf_state_t s_d;

    // Next state: defaults, then commit, then single writes
    always_comb begin
        s_d = s_q;
        s_d.rd_data = s_q.regs[rd_addr];
        if (load_default) begin
            s_d.regs = RF_DEFAULTS; // RULE20
            s_d.staged = '0;
        end
        if (stage_en) begin
            // Staging keeps the live set untouched until the checksum is known
            s_d.stage[stage_addr] = stage_data;
            s_d.staged[stage_addr] = 1'b1;
        end
        if (commit) begin
            for (int i = 0; i < NREG; i++) begin
                if (s_q.staged[i]) begin
                    s_d.regs[i] = s_q.stage[i]; // RULE20
                end
            end
            s_d.staged = '0;
        end
        if (discard) begin
            // Bad load: live set keeps its defaults and the strap write
            s_d.staged = '0; // RULE21
        end
        if (wr_en) begin
            s_d.regs[wr_addr] = wr_data; // RULE4
        end
    end

    // Register the whole state
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '{regs: RF_DEFAULTS, stage: '0, staged: '0, rd_data: '0}; // RULE19
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_data = s_q.rd_data;
    assign regs_out = s_q.regs;
endmodule // cfg_reg_file

// ### design/reset_strap_config_select.sv
// Contract
// RULE1 - Capture every pin at master reset release
// RULE2 - Pin nine low SPI, high two-wire
// RULE3 - Board holds pin eight high during reset
// RULE4 - Strap-derived settings stay writable afterwards
// RULE5 - No address pin assigned: bit two zero
// RULE6 - Address strap ignored when port runs SPI
// RULE7 - Several address pins: highest index wins
// RULE8 - Disable pin high blocks EEPROM reads
// RULE9 - No disable pin: always search EEPROM
// RULE10 - Any disable pin high disables EEPROM
// RULE11 - No select pins: use pins three..zero
// RULE12 - Undriven pulled-up select pins give fifteen
// RULE13 - Select pins packed lowest index first
// RULE14 - Fewer than four: upper index bits zero
// RULE15 - More than four: wider index
// RULE16 - Factory block may pick arbitrary pins
// RULE17 - Index picks stored config; none stored, ignored
// RULE18 - Pin roles from factory block, else defaults
// RULE19 - Defaults: clocks off, pins plain inputs
// RULE20 - Defaults first, then selected stored config
// RULE21 - Checksum failure keeps registers at defaults
// RULE22 - Captured straps hold until next reset
`timescale 1ns/1ps
module reset_strap_config_select import strap_cfg_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst_b,
    // Pin levels, already synchronous to clk_sys
    input wire logic [NUM_GPIO-1:0] gpio_in,
    // Pin role assignment from the factory information block
    input wire logic info_valid,
    input wire logic [NUM_GPIO-1:0] addr2_pin_mask,
    input wire logic [NUM_GPIO-1:0] eeprom_dis_pin_mask,
    input wire logic [NUM_GPIO-1:0] cfg_sel_pin_mask,
    // Stored configuration reader
    input wire logic nvm_present,
    output logic nvm_req,
    output logic [CFG_IDX_W-1:0] nvm_index,
    input wire logic nvm_valid,
    input wire logic [NVM_ADDR_W-1:0] nvm_addr,
    input wire logic [REG_W-1:0] nvm_data,
    input wire logic nvm_last,
    // Serial port register access after start-up
    input wire logic host_wr_en,
    input wire logic [REG_IDX_W-1:0] host_addr,
    input wire logic [REG_W-1:0] host_wr_data,
    output logic [REG_W-1:0] host_rd_data,
    output logic host_ready,
    // Start-up results
    output logic [NUM_GPIO-1:0] captured_levels,
    output logic main_port_i2c,
    output logic slave_addr_bit_two,
    output logic eeprom_search_en,
    output logic [CFG_IDX_W-1:0] cfg_index,
    output logic strap_fault,
    output logic checksum_fail,
    output logic [REG_W-1:0] clk_out_en,
    output logic [2*REG_W-1:0] gpio_mode
);
    // =========================================================
    // State of the start-up sequencer
    typedef struct packed {
        boot_state_t st;                 // Sequencer position
        logic [NUM_GPIO-1:0] straps;     // Levels caught at reset release
        logic [CFG_IDX_W-1:0] cfg_index; // Stored configuration index
        logic eeprom_dis;                // EEPROM search suppressed
        logic [REG_W-1:0] csum;          // Running sum of loaded words
        logic strap_fault;               // Must-high pin was low
        logic csum_fail;                 // Last load rejected
    } boot_q_t;

    boot_q_t s_q;
    boot_q_t s_d;

    // =========================================================
    // Role decoding of the captured straps
    // Roles only count when the factory block is programmed
    logic [NUM_GPIO-1:0] addr2_mask;
    logic [NUM_GPIO-1:0] dis_mask;
    logic [NUM_GPIO-1:0] sel_mask;

    // Unprogrammed parts fall back to the default roles
    assign addr2_mask = info_valid ? addr2_pin_mask : '0; // RULE18
    assign dis_mask = info_valid ? eeprom_dis_pin_mask : '0; // RULE18
    assign sel_mask = info_valid ? cfg_sel_pin_mask : '0; // RULE16

    // Address bit two source
    logic addr2_val;
    logic addr2_any;

    strap_gather u_addr2 (
        .level(s_q.straps),
        .mask(addr2_mask),
        .packed_val(),
        .top_val(addr2_val),
        .any_high(),
        .any_sel(addr2_any)
    );

    // EEPROM disable source
    logic dis_any_high;

    strap_gather u_eeprom_dis (
        .level(s_q.straps),
        .mask(dis_mask),
        .packed_val(),
        .top_val(),
        .any_high(dis_any_high),
        .any_sel()
    );

    // Configuration select source
    logic [NUM_GPIO-1:0] sel_packed;
    logic sel_any;

    strap_gather u_cfg_sel (
        .level(s_q.straps),
        .mask(sel_mask),
        .packed_val(sel_packed),
        .top_val(),
        .any_high(),
        .any_sel(sel_any)
    );

    // =========================================================
    // Derived start-up values
    logic [CFG_IDX_W-1:0] idx_from_straps;
    logic addr2_bit;
    logic proto_i2c;

    always_comb begin
        // No select pins assigned: the low four pins are the index
        if (sel_any) begin
            idx_from_straps = sel_packed; // RULE15
        end else begin
            // Pull-ups make a floating group read as all ones, index fifteen
            idx_from_straps = CFG_IDX_W'(s_q.straps[DFLT_IDX_W-1:0]); // RULE11 RULE12
        end
        // Without an assigned pin the address bit stays zero
        addr2_bit = addr2_any ? addr2_val : 1'b0; // RULE5
        proto_i2c = s_q.straps[PROTO_PIN]; // RULE2
    end

    // =========================================================
    // Register file
    logic rf_default;
    logic rf_wr_en;
    logic [REG_IDX_W-1:0] rf_wr_addr;
    logic [REG_W-1:0] rf_wr_data;
    logic rf_stage_en;
    logic rf_commit;
    logic rf_discard;
    logic [NREG-1:0][REG_W-1:0] rf_regs;
    logic nvm_in_range;

    // Words aimed past the last register are summed but not stored
    assign nvm_in_range = (nvm_addr < NVM_ADDR_W'(NREG));

    cfg_reg_file u_regs (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .load_default(rf_default),
        .wr_en(rf_wr_en),
        .wr_addr(rf_wr_addr),
        .wr_data(rf_wr_data),
        .stage_en(rf_stage_en),
        .stage_addr(nvm_addr[REG_IDX_W-1:0]),
        .stage_data(nvm_data),
        .commit(rf_commit),
        .discard(rf_discard),
        .rd_addr(host_addr),
        .rd_data(host_rd_data),
        .regs_out(rf_regs)
    );

    // =========================================================
    // Sequencer next state and strobes
    always_comb begin
        s_d = s_q;
        rf_default = 1'b0;
        rf_wr_en = 1'b0;
        rf_wr_addr = host_addr;
        rf_wr_data = host_wr_data;
        rf_stage_en = 1'b0;
        rf_commit = 1'b0;
        rf_discard = 1'b0;
        nvm_req = 1'b0;
        unique case (s_q.st)
            S_CAPTURE: begin
                // First edge after release: the pins are caught once here
                s_d.straps = gpio_in; // RULE1
                s_d.st = S_DEFAULT;
            end
            S_DEFAULT: begin
                // Registers return to defaults before anything is applied
                rf_default = 1'b1; // RULE20
                s_d.cfg_index = idx_from_straps; // RULE13
                // Any one high disable pin wins; no pin means search
                s_d.eeprom_dis = dis_any_high; // RULE8 RULE9 RULE10
                // The board is expected to keep pin eight high; flag it if not
                s_d.strap_fault = !s_q.straps[MUST_HIGH_PIN]; // RULE3
                s_d.st = S_STRAP;
            end
            S_STRAP: begin
                // Strap results go in as an ordinary register write
                rf_wr_en = 1'b1; // RULE4
                rf_wr_addr = REG_PORT_CFG;
                rf_wr_data = RST_PORT_CFG;
                rf_wr_data[PORT_CFG_I2C_BIT] = proto_i2c; // RULE2
                rf_wr_data[PORT_CFG_ADDR2_BIT] = addr2_bit; // RULE7
                // Parts with nothing stored skip the request and load entirely
                s_d.st = nvm_present ? S_REQ : S_DONE; // RULE17
            end
            S_REQ: begin
                // One-cycle request carrying the index
                nvm_req = 1'b1; // RULE17
                s_d.csum = '0;
                s_d.st = S_LOAD;
            end
            S_LOAD: begin
                if (nvm_valid) begin
                    rf_stage_en = nvm_in_range;
                    s_d.csum = s_q.csum + nvm_data;
                    if (nvm_last) begin
                        s_d.st = S_CHECK;
                    end
                end
            end
            S_CHECK: begin
                // Only a clean sum lets the staged words reach the registers
                if (s_q.csum == CSUM_GOOD) begin
                    rf_commit = 1'b1; // RULE20
                end else begin
                    rf_discard = 1'b1; // RULE21
                    s_d.csum_fail = 1'b1;
                end
                s_d.st = S_DONE;
            end
            S_DONE: begin
                // Serial port owns the registers from here on
                rf_wr_en = host_wr_en; // RULE4
                // Straps are left alone until the next reset
                s_d.straps = s_q.straps; // RULE22
            end
            default: begin
                // Illegal code: restart the sequence cleanly
                s_d.st = S_CAPTURE;
            end
        endcase
    end

    // =========================================================
    // State register
    // Asynchronous reset loads constants only; pins are caught after release
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '{st: S_CAPTURE, straps: '0, cfg_index: '0, eeprom_dis: 1'b0,
                     csum: '0, strap_fault: 1'b0, csum_fail: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // =========================================================
    // Outputs
    assign host_ready = (s_q.st == S_DONE);
    assign captured_levels = s_q.straps; // RULE22
    assign nvm_index = s_q.cfg_index;
    assign cfg_index = s_q.cfg_index;
    // Search only once start-up is settled and no disable pin is high
    assign eeprom_search_en = (s_q.st == S_DONE) && !s_q.eeprom_dis; // RULE8 RULE9
    assign strap_fault = s_q.strap_fault;
    assign checksum_fail = s_q.csum_fail;
    assign main_port_i2c = rf_regs[REG_PORT_CFG][PORT_CFG_I2C_BIT];
    // The address bit means nothing on an SPI port, so it reads zero there
    assign slave_addr_bit_two = main_port_i2c && rf_regs[REG_PORT_CFG][PORT_CFG_ADDR2_BIT]; // RULE6
    assign clk_out_en = rf_regs[REG_CLK_OUT_EN]; // RULE19
    assign gpio_mode = {rf_regs[REG_GPIO_MODE_HI], rf_regs[REG_GPIO_MODE_LO]}; // RULE19
endmodule // reset_strap_config_select

// ### testbench/strap_rules_sva.sv
`timescale 1ns/1ps
// ==========
// Start-up strap checker
module strap_rules_sva import strap_cfg_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic info_valid,
    input wire logic [NUM_GPIO-1:0] eeprom_dis_pin_mask,
    input wire logic nvm_present,
    input wire logic nvm_req,
    input wire logic [CFG_IDX_W-1:0] nvm_index,
    input wire logic host_wr_en,
    input wire logic [REG_IDX_W-1:0] host_addr,
    input wire logic [REG_W-1:0] host_wr_data,
    input wire logic host_ready,
    input wire logic [NUM_GPIO-1:0] captured_levels,
    input wire logic slave_addr_bit_two,
    input wire logic main_port_i2c,
    input wire logic eeprom_search_en,
    input wire logic [CFG_IDX_W-1:0] cfg_index,
    input wire logic strap_fault,
    input wire logic [REG_W-1:0] clk_out_en
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    property p_hold; host_ready |-> $stable(captured_levels); endproperty
    a_hold: assert property (p_hold) else $error("caught straps moved");
    property p_spi; slave_addr_bit_two |-> main_port_i2c; endproperty
    a_spi: assert property (p_spi) else $error("address bit set under SPI");
    property p_srch;
        host_ready |-> eeprom_search_en == !(info_valid && |(eeprom_dis_pin_mask & captured_levels));
    endproperty
    a_srch: assert property (p_srch) else $error("search enable wrong");
    property p_pulse; nvm_req |=> !nvm_req; endproperty
    a_pulse: assert property (p_pulse) else $error("request not a pulse");
    property p_none; !nvm_present |-> !nvm_req; endproperty
    a_none: assert property (p_none) else $error("request with no store");
    // Ties the requested index to the caught pins, not to its own register copy
    property p_idx; nvm_req && !info_valid |-> nvm_index == CFG_IDX_W'(captured_levels[3:0]); endproperty
    a_idx: assert property (p_idx) else $error("requested index wrong");
    property p_dflt; host_ready && !info_valid |-> cfg_index == CFG_IDX_W'(captured_levels[3:0]); endproperty
    a_dflt: assert property (p_dflt) else $error("default index wrong");
    property p_flt; host_ready |-> strap_fault == !captured_levels[MUST_HIGH_PIN]; endproperty
    a_flt: assert property (p_flt) else $error("fault flag wrong");
    property p_wr;
        host_ready && host_wr_en && host_addr == REG_CLK_OUT_EN |=> clk_out_en == $past(host_wr_data);
    endproperty
    a_wr: assert property (p_wr) else $error("write lost");
    // Bound keeps a hung sequencer visible; slow loads stay well inside it
    property p_done; $rose(rst_b) |-> ##[3:60] host_ready; endproperty
    a_done: assert property (p_done) else $error("start-up too long");
endmodule // strap_rules_sva

bind reset_strap_config_select strap_rules_sva u_sva (.clk_sys(clk_sys), .rst_b(rst_b), .info_valid(info_valid),
    .eeprom_dis_pin_mask(eeprom_dis_pin_mask), .nvm_present(nvm_present), .nvm_req(nvm_req),
    .nvm_index(nvm_index), .host_wr_en(host_wr_en), .host_addr(host_addr), .host_wr_data(host_wr_data),
    .host_ready(host_ready), .captured_levels(captured_levels), .slave_addr_bit_two(slave_addr_bit_two),
    .main_port_i2c(main_port_i2c), .eeprom_search_en(eeprom_search_en), .cfg_index(cfg_index),
    .strap_fault(strap_fault), .clk_out_en(clk_out_en));

// ### testbench/board_strap_model.sv
`timescale 1ns/1ps
// ==========
// Board straps and stored config store
module board_strap_model (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [15:0] drive_en,
    input wire logic [15:0] drive_val,
    output logic [15:0] gpio_in,
    input wire logic nvm_req,
    input wire logic [7:0] cfg_word,
    input wire logic bad_sum,
    input wire logic [3:0] gap,
    output logic nvm_valid,
    output logic [7:0] nvm_addr,
    output logic [7:0] nvm_data,
    output logic nvm_last
);
    logic [15:0] pads; // Pin level after pull-ups
    // Undriven pins float high through the pull-ups
    assign pads = (drive_en & drive_val) | ~drive_en;
    // Pin eight held high while reset is active
    assign gpio_in = rst_b ? pads : (pads | 16'h0100);
    // Idle lines toggle so a stale word never looks valid
    task automatic idle();
        nvm_valid <= 1'b0;
        nvm_last <= 1'b0;
        nvm_addr <= ~nvm_addr;
        nvm_data <= ~nvm_data;
    endtask
    initial begin
        nvm_valid = 1'b0;
        nvm_last = 1'b0;
        nvm_addr = 8'h00;
        nvm_data = 8'h00;
        forever begin
            @(posedge clk_sys);
            // Answer a request: data word, then checksum word flagged last
            if (nvm_req === 1'b1) begin
                repeat (gap) begin
                    idle();
                    @(posedge clk_sys);
                end
                nvm_valid <= 1'b1;
                nvm_addr <= 8'h00;
                nvm_data <= cfg_word;
                @(posedge clk_sys);
                nvm_addr <= 8'h08;
                nvm_data <= 8'h00 - cfg_word + {7'h00, bad_sum};
                nvm_last <= 1'b1;
            end else begin
                idle();
            end
        end
    end
endmodule // board_strap_model

// ### testbench/tb_top.sv
`timescale 1ns/1ps
// ==========
// Strap capture bench
module tb_top import strap_cfg_pkg::*; ;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic info_valid = 1'b0;
    logic [15:0] am = '0, dm = '0, sm = '0, de = '0, dv = '0;
    logic nvm_present = 1'b0;
    logic nvm_req, nvm_valid, nvm_last, bad = 1'b0;
    logic [15:0] gpio_in, nvm_index, cfg_index, captured_levels, gpio_mode;
    logic [7:0] nvm_addr, nvm_data, cw = '0, host_rd_data, clk_out_en, host_wr_data = '0;
    logic [3:0] gp = '0;
    logic host_wr_en = 1'b0, host_ready, main_port_i2c, slave_addr_bit_two;
    logic eeprom_search_en, strap_fault, checksum_fail;
    logic [2:0] host_addr = '0;
    int error_cnt = 0;
    int num_checks = 0;
    // 4 ns period
    always #2 clk_sys = ~clk_sys;
    reset_strap_config_select dut (.clk_sys(clk_sys), .rst_b(rst_b), .gpio_in(gpio_in), .info_valid(info_valid),
        .addr2_pin_mask(am), .eeprom_dis_pin_mask(dm), .cfg_sel_pin_mask(sm), .nvm_present(nvm_present),
        .nvm_req(nvm_req), .nvm_index(nvm_index), .nvm_valid(nvm_valid), .nvm_addr(nvm_addr), .nvm_data(nvm_data),
        .nvm_last(nvm_last), .host_wr_en(host_wr_en), .host_addr(host_addr), .host_wr_data(host_wr_data),
        .host_rd_data(host_rd_data), .host_ready(host_ready), .captured_levels(captured_levels),
        .main_port_i2c(main_port_i2c), .slave_addr_bit_two(slave_addr_bit_two),
        .eeprom_search_en(eeprom_search_en), .cfg_index(cfg_index), .strap_fault(strap_fault),
        .checksum_fail(checksum_fail), .clk_out_en(clk_out_en), .gpio_mode(gpio_mode));
    board_strap_model board (.clk_sys(clk_sys), .rst_b(rst_b), .drive_en(de), .drive_val(dv), .gpio_in(gpio_in),
        .nvm_req(nvm_req), .cfg_word(cw), .bad_sum(bad), .gap(gp), .nvm_valid(nvm_valid), .nvm_addr(nvm_addr),
        .nvm_data(nvm_data), .nvm_last(nvm_last));
    // ==========
    // Helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Reset with new straps and roles, then wait for start-up to finish
    task automatic boot(input logic iv, input logic [15:0] a, d, s, e, v, input logic p, input logic [7:0] w,
                        input logic b, input logic [3:0] g);
        int n;
        @(posedge clk_sys);
        rst_b <= 1'b0;
        info_valid <= iv;
        am <= a;
        dm <= d;
        sm <= s;
        de <= e;
        dv <= v;
        nvm_present <= p;
        cw <= w;
        bad <= b;
        gp <= g;
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        for (n = 0; n < 100 && host_ready !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
        end
        chk(16'(host_ready), 16'h1, "ready");
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        host_wr_en <= 1'b1;
        host_addr <= a;
        host_wr_data <= d;
        @(posedge clk_sys);
        host_wr_en <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        host_addr <= a;
        @(posedge clk_sys);
        #1;
        chk(16'(host_rd_data), 16'(exp), "read");
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Cuts a hang short
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        final_report();
    end
    // ==========
    // Scenarios
    initial begin
        // Factory block blank: its masks must be ignored, pin nine low
        boot(0, 16'h0080, 16'hffff, 16'h00f0, 16'h0200, 16'h0000, 0, 8'h00, 0, 0);
        chk(captured_levels, 16'hfdff, "caught");
        chk(16'(main_port_i2c), 16'h0, "spi");
        chk(16'(slave_addr_bit_two), 16'h0, "a2 none");
        chk(16'(eeprom_search_en), 16'h1, "search");
        chk(cfg_index, 16'h000f, "pulled up");
        chk({8'h00, clk_out_en}, 16'h0, "clk off");
        chk(gpio_mode, 16'h0000, "inputs");
        rd(3'h7, 8'h00);
        wr(REG_PORT_CFG, 8'h03);
        chk(16'({main_port_i2c, slave_addr_bit_two}), 16'h3, "rewrite");
        rd(REG_PORT_CFG, 8'h03);
        wr(REG_CLK_OUT_EN, 8'h81);
        wr(REG_GPIO_MODE_LO, 8'ha5);
        chk(gpio_mode, 16'h00a5, "mode");
        // Pins move after start-up: nothing caught may follow
        @(posedge clk_sys);
        de <= 16'hffff;
        dv <= 16'h0000;
        repeat (5) @(posedge clk_sys);
        #1;
        chk(captured_levels, 16'hfdff, "held");
        chk(cfg_index, 16'h000f, "idx held");
        // Two address pins, two disable pins, scattered select pins, good load
        boot(1, 16'h00a0, 16'h0c00, 16'h1054, 16'h1ef4, 16'h1a94, 1, 8'h5a, 0, 0);
        chk(captured_levels, 16'hfb9f, "caught2");
        chk(16'(slave_addr_bit_two), 16'h1, "a2 top");
        chk(16'(eeprom_search_en), 16'h0, "disabled");
        chk(cfg_index, 16'h000b, "scattered");
        chk({8'h00, clk_out_en}, 16'h005a, "loaded");
        chk(16'(checksum_fail), 16'h0, "good sum");
        // Address strap under SPI, two select pins, slow store, bad sum
        boot(1, 16'h0080, 16'h0000, 16'h4002, 16'h0280, 16'h0080, 1, 8'h33, 1, 4'h3);
        chk(16'(slave_addr_bit_two), 16'h0, "a2 spi");
        chk(16'(eeprom_search_en), 16'h1, "search2");
        chk(cfg_index, 16'h0003, "narrow");
        chk(16'(checksum_fail), 16'h1, "bad sum");
        chk({8'h00, clk_out_en}, 16'h0000, "kept");
        // No address pin under two-wire, five select pins, unprogrammed store
        boot(1, 16'h0000, 16'h0000, 16'ha409, 16'ha409, 16'h8401, 0, 8'h00, 0, 0);
        chk(captured_levels, 16'hdff7, "caught4");
        chk(16'({main_port_i2c, slave_addr_bit_two}), 16'h2, "a2 zero");
        chk(cfg_index, 16'h0015, "wide");
        final_report();
    end
endmodule // tb_top
